// file: design/nfc_host.sv
`timescale 1ns/1ps
module nfc_host
  import nfc_pkg::*;
(
  input  wire logic                i_core_clk,     // 25 MHz clock
  input  wire logic                i_srst,         // sync reset, active high
  input  wire nfc_pkg::nfc_req_s   i_req,          // request word
  input  wire logic                i_req_valid,    // request offered
  output logic                     o_req_ready,    // request taken
  input  wire logic                i_wp_release,   // allow program and erase
  output logic [7:0]               o_rd_data,      // byte read from device
  output logic                     o_rd_valid,     // read byte available
  input  wire logic                i_rd_ready,     // consumer takes read byte
  output logic                     o_busy,         // sequence in progress
  output logic                     o_illegal,      // refused command pulse
  output nfc_pkg::nfc_pins_s       o_pins,         // control pins
  output logic [7:0]               o_io_out,       // io drive value
  output logic                     o_io_oe,        // io drive enable
  input  wire logic [7:0]          i_io_in,        // io pin level
  input  wire logic                i_ready_busy_n  // device ready, open drain
);
  import nfc_pkg::*;

  // =====================================================================
  // pin synchronisers
  logic       rb_s1_reg, rb_s2_reg;
  logic [7:0] io_s1_reg, io_s2_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rb_s1_reg <= 1'b0;
      rb_s2_reg <= 1'b0;
      io_s1_reg <= 8'h00;
      io_s2_reg <= 8'h00;
    end else begin
      rb_s1_reg <= i_ready_busy_n;
      rb_s2_reg <= rb_s1_reg;
      io_s1_reg <= i_io_in;
      io_s2_reg <= io_s1_reg;
    end
  end

  // =====================================================================
  // read fifo: a stalled consumer stalls read cycles
  logic       rf_in_valid, rf_in_ready;
  logic [7:0] rf_in_data;
  nfc_fifo #(.W(FIFO_W), .D(FIFO_D)) nfc_fifo_inst (
    .i_core_clk  (i_core_clk),
    .i_srst      (i_srst),
    .i_in_valid  (rf_in_valid),
    .i_in_data   (rf_in_data),
    .o_in_ready  (rf_in_ready),
    .o_out_valid (o_rd_valid),
    .i_out_ready (i_rd_ready),
    .o_out_data  (o_rd_data)
  );

  // =====================================================================
  // cycle engine
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOW   = 3'b001,
    ST_HIGH  = 3'b010,
    ST_WB    = 3'b011,
    ST_WAIT  = 3'b100,
    ST_SETTL = 3'b101
  } nfc_st_e;

  nfc_st_e    st_reg, st_next;
  nfc_req_s   cur_reg, cur_next;
  nfc_pins_s  pins_reg, pins_next;
  logic [7:0] io_reg, io_next;
  logic       oe_reg, oe_next;
  logic [7:0] cnt_reg, cnt_next;
  logic       ill_reg, ill_next;
  logic       dev_busy, take, cmd_ok, is_wr_op, is_prog_cmd;

  assign dev_busy    = !rb_s2_reg;
  assign is_prog_cmd = (i_req.data == CMD_PROG_SETUP) || (i_req.data == CMD_COPY_PROG)
                    || (i_req.data == CMD_ERASE_SETUP);
  // busy device only hears status and reset
  assign cmd_ok = !dev_busy || (i_req.data == CMD_STATUS) || (i_req.data == CMD_RESET);
  assign take   = (st_reg == ST_IDLE) && i_req_valid
               && !(i_req.op == NFC_OP_RD && !rf_in_ready)
               && !(i_req.op != NFC_OP_CMD && i_req.op != NFC_OP_WAIT && dev_busy);
  assign o_req_ready = take;
  assign o_busy      = (st_reg != ST_IDLE);
  assign o_illegal   = ill_reg;
  assign o_pins      = pins_reg;
  assign o_io_out    = io_reg;
  assign o_io_oe     = oe_reg;
  assign is_wr_op    = (cur_reg.op != NFC_OP_RD);
  // sample once the strobe has risen again: the two-stage sync then holds the byte
  // driven at the falling strobe; relies on the device keeping its drivers on (edo)
  assign rf_in_valid = (st_reg == ST_SETTL) && !is_wr_op && (cnt_reg == CNT_RESET);
  assign rf_in_data  = io_s2_reg;

  always_comb begin
    st_next   = st_reg;
    cur_next  = cur_reg;
    pins_next = pins_reg;
    io_next   = io_reg;
    oe_next   = oe_reg;
    cnt_next  = (cnt_reg != CNT_RESET) ? cnt_reg - 8'h01 : CNT_RESET;
    ill_next  = 1'b0;
    pins_next.write_protect_n = i_wp_release;
    case (st_reg)
      ST_IDLE: begin
        // strobes parked high between cycles and while busy
        pins_next.write_strobe_n  = 1'b1;
        pins_next.output_strobe_n = 1'b1;
        if (take) begin
          cur_next = i_req;
          if (i_req.op == NFC_OP_CMD && (!cmd_ok || (is_prog_cmd && !i_wp_release))) begin
            ill_next = 1'b1;
          end else if (i_req.op == NFC_OP_WAIT) begin
            cnt_next = 8'(WB_CYC);
            st_next  = ST_WB;
          end else begin
            pins_next.chip_sel_n = 1'b0;
            pins_next.cmd_latch  = (i_req.op == NFC_OP_CMD);
            pins_next.addr_latch = (i_req.op == NFC_OP_ADDR);
            io_next  = i_req.data;
            oe_next  = (i_req.op != NFC_OP_RD);
            cnt_next = 8'(STROBE_HIGH_CYC);
            st_next  = ST_LOW;
          end
        end
      end
      ST_LOW: begin
        // latch levels settled two cycles before the falling strobe
        if (cnt_reg == CNT_RESET) begin
          pins_next.write_strobe_n  = !is_wr_op;
          pins_next.output_strobe_n = is_wr_op;
          cnt_next = 8'(STROBE_LOW_CYC);
          st_next  = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (cnt_reg == CNT_RESET) begin
          // rising write edge latches the cycle; each data byte steps the column
          pins_next.write_strobe_n  = 1'b1;
          pins_next.output_strobe_n = 1'b1;
          cnt_next = 8'(STROBE_HIGH_CYC);
          st_next  = ST_SETTL;
        end
      end
      ST_SETTL: begin
        if (cnt_reg == CNT_RESET) begin
          pins_next.cmd_latch  = 1'b0;
          pins_next.addr_latch = 1'b0;
          oe_next = 1'b0;
          // commands that start array work need the busy window
          if (cur_reg.op == NFC_OP_CMD && (cur_reg.data == CMD_READ_START
              || cur_reg.data == CMD_CACHE_NEXT || cur_reg.data == CMD_CACHE_LAST
              || cur_reg.data == CMD_PROG_START || cur_reg.data == CMD_CACHE_PROG
              || cur_reg.data == CMD_COPY_READ || cur_reg.data == CMD_ERASE_START
              || cur_reg.data == CMD_COL_OUT_GO || cur_reg.data == CMD_RESET)) begin
            cnt_next = 8'(WB_CYC);
            st_next  = ST_WB;
          end else begin
            st_next = ST_IDLE;
          end
        end
      end
      ST_WB: begin
        if (cnt_reg == CNT_RESET) begin
          st_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // busy covers array load, cache transfer and program-verify loops
        if (!dev_busy) begin
          cnt_next = 8'(RB_SETTLE_CYC);
          st_next  = ST_SETTL;
          cur_next.op = NFC_OP_WAIT;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_reg   <= ST_IDLE;
      cur_reg  <= '0;
      pins_reg <= '{cmd_latch: 1'b0, addr_latch: 1'b0, chip_sel_n: 1'b1,
                    write_strobe_n: 1'b1, output_strobe_n: 1'b1, write_protect_n: 1'b0};
      io_reg   <= 8'h00;
      oe_reg   <= 1'b0;
      cnt_reg  <= CNT_RESET;
      ill_reg  <= 1'b0;
    end else begin
      st_reg   <= st_next;
      cur_reg  <= cur_next;
      pins_reg <= pins_next;
      io_reg   <= io_next;
      oe_reg   <= oe_next;
      cnt_reg  <= cnt_next;
      ill_reg  <= ill_next;
    end
  end

  // =====================================================================
  // checks
  a_cycle_select: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $rose(pins_reg.write_strobe_n) |-> !pins_reg.chip_sel_n && pins_reg.output_strobe_n
      && !(pins_reg.cmd_latch && pins_reg.addr_latch)) else $error("bad latch at strobe");
  a_wp_follow: assert property (@(posedge i_core_clk) disable iff (i_srst)
    ##1 pins_reg.write_protect_n == $past(i_wp_release)) else $error("wp not following");
  a_busy_strobes: assert property (@(posedge i_core_clk) disable iff (i_srst)
    st_reg == ST_WAIT |-> pins_reg.write_strobe_n && pins_reg.output_strobe_n)
    else $error("strobe moved while busy");
  a_busy_cmd: assert property (@(posedge i_core_clk) disable iff (i_srst)
    take && i_req.op == NFC_OP_CMD && dev_busy && i_req.data != CMD_STATUS
      && i_req.data != CMD_RESET |=> ill_reg) else $error("busy command not refused");
  a_start_wait: assert property (@(posedge i_core_clk) disable iff (i_srst)
    st_reg == ST_SETTL && cnt_reg == CNT_RESET && cur_reg.op == NFC_OP_CMD
      && cur_reg.data == CMD_READ_START |=> st_reg == ST_WB) else $error("no busy wait");
  a_read_oe: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !pins_reg.output_strobe_n |-> !oe_reg) else $error("host drives io on read");
  a_strobe_width: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $fell(pins_reg.write_strobe_n) |=> !pins_reg.write_strobe_n) else $error("short pulse");
  a_settle_wait: assert property (@(posedge i_core_clk) disable iff (i_srst)
    st_reg == ST_WAIT && !dev_busy |=> st_reg == ST_SETTL ##1 st_reg == ST_SETTL)
    else $error("no settle after ready");

  c_cmd_cycle: cover property (@(posedge i_core_clk) take && i_req.op == NFC_OP_CMD);
  c_read_byte: cover property (@(posedge i_core_clk) rf_in_valid && rf_in_ready);
  c_busy_wait: cover property (@(posedge i_core_clk) st_reg == ST_WAIT ##1 !dev_busy);
  c_refused:   cover property (@(posedge i_core_clk) ill_reg);
endmodule

// file: common/nfc_pkg.sv
package nfc_pkg;

  // =====================================================================
  // command codes
  localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
  localparam logic [7:0] CMD_READ_START   = 8'h30;
  localparam logic [7:0] CMD_COL_OUT      = 8'h05;
  localparam logic [7:0] CMD_COL_OUT_GO   = 8'hE0;
  localparam logic [7:0] CMD_CACHE_NEXT   = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST   = 8'h3F;
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h80;
  localparam logic [7:0] CMD_PROG_START   = 8'h10;
  localparam logic [7:0] CMD_COL_IN       = 8'h85;
  localparam logic [7:0] CMD_CACHE_PROG   = 8'h15;
  localparam logic [7:0] CMD_COPY_READ    = 8'h3A;
  localparam logic [7:0] CMD_COPY_PROG    = 8'h8C;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h60;
  localparam logic [7:0] CMD_ERASE_START  = 8'hD0;
  localparam logic [7:0] CMD_ID_READ      = 8'h90;
  localparam logic [7:0] CMD_STATUS       = 8'h70;
  localparam logic [7:0] CMD_RESET        = 8'hFF;

  // =====================================================================
  // timing, in 40 ns cycles at 25 MHz
  localparam int CLK_NS          = 40;
  localparam int STROBE_LOW_NS   = 12;
  localparam int STROBE_HIGH_NS  = 30;
  localparam int WB_NS           = 100;
  localparam int STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WB_CYC          = (WB_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int RB_SETTLE_CYC   = 4;
  localparam logic [7:0] CNT_RESET = 8'h00;

  // =====================================================================
  // fifo geometry
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 32;

  // =====================================================================
  // request kinds
  typedef enum logic [2:0] {
    NFC_OP_CMD  = 3'b000,
    NFC_OP_ADDR = 3'b001,
    NFC_OP_WR   = 3'b010,
    NFC_OP_RD   = 3'b011,
    NFC_OP_WAIT = 3'b100
  } nfc_op_e;

  typedef struct packed {
    nfc_op_e    op;
    logic [7:0] data;
  } nfc_req_s;

  typedef struct packed {
    logic       cmd_latch;
    logic       addr_latch;
    logic       chip_sel_n;
    logic       write_strobe_n;
    logic       output_strobe_n;
    logic       write_protect_n;
  } nfc_pins_s;

endpackage

// file: design/nfc_fifo.sv
`timescale 1ns/1ps
module nfc_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         i_core_clk,  // clock
  input  wire logic         i_srst,      // sync reset
  input  wire logic         i_in_valid,  // write request
  output logic              o_in_ready,  // space available
  input  wire logic [W-1:0] i_in_data,   // write data
  output logic              o_out_valid, // data available
  input  wire logic         i_out_ready, // consumer takes word
  output logic [W-1:0]      o_out_data   // head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          push, pop;

  assign o_in_ready  = (cnt_reg != D[AW:0]);
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data  = mem_reg[rp_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    wp_next  = push ? wp_reg + 1'b1 : wp_reg;
    rp_next  = pop ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
    if (push) begin
      mem_reg[wp_reg] <= i_in_data;
    end
  end

  a_fifo_no_overflow: assert property (@(posedge i_core_clk) disable iff (i_srst)
    cnt_reg <= D[AW:0]) else $error("fifo count above depth");
endmodule

// file: tb/nfc_dev_model.sv
`timescale 1ns/1ps
module nfc_dev_model
  import nfc_pkg::*;
#(
  parameter int BUSY_NS = 2000  // array load and program busy span
) (
  input  wire nfc_pkg::nfc_pins_s i_pins,        // host control pins
  input  wire logic [7:0]         i_host_io,     // host io drive
  input  wire logic               i_host_oe,     // host io enable
  output logic [7:0]              o_io,          // io wire level
  output logic                    o_ready_busy_n // open drain, pulled up
);
  logic [7:0] mem [0:63];
  logic [7:0] pgbuf [0:15];
  logic [7:0] cache [0:15];
  logic [7:0] dout;
  logic       drv;
  logic [3:0] col;
  logic [1:0] row;
  logic [1:0] nxt;
  int         acnt;
  // =====================================================================
  // power-on state: read setup already latched
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'h5A;
    drv = 1'b0;
    dout = 8'h00;
    col = 4'h0;
    row = 2'h0;
    nxt = 2'h0;
    acnt = 0;
    o_ready_busy_n = 1'b1;
  end
  // blocking wait: no strobes are expected while busy
  task automatic go_busy(input int ns);
    o_ready_busy_n = 1'b0;
    #(ns);
    o_ready_busy_n = 1'b1;
  endtask
  task automatic load(input logic [1:0] r, input logic [3:0] c);
    for (int i = 0; i < 16; i++) cache[i] = mem[{r, 4'(i)}];
    col = c;
  endtask
  always @(posedge i_pins.write_strobe_n) begin
    if (!i_pins.chip_sel_n && i_pins.output_strobe_n) begin
      if (i_pins.cmd_latch && !i_pins.addr_latch) begin
        acnt = 0;
        case (i_host_io)
          8'h30: begin load(row, col); nxt = row + 2'h1; go_busy(BUSY_NS); end
          8'h31: begin load(nxt, 4'h0); nxt = nxt + 2'h1; go_busy(BUSY_NS / 4); end
          8'h3F: begin load(nxt, 4'h0); go_busy(BUSY_NS / 4); end
          8'h80: if (i_pins.write_protect_n) begin
            for (int i = 0; i < 16; i++) pgbuf[i] = 8'hFF;
          end
          8'h10: if (i_pins.write_protect_n) begin
            for (int i = 0; i < 16; i++) mem[{row, 4'(i)}] = pgbuf[i];
            go_busy(BUSY_NS);
          end
          8'h15, 8'h3A, 8'hD0, 8'hFF: go_busy(BUSY_NS / 4);
          default: ;
        endcase
      end else if (i_pins.addr_latch && !i_pins.cmd_latch) begin
        if (acnt == 0) col = i_host_io[3:0];
        if (acnt == 2) row = i_host_io[1:0];
        acnt++;
      end else if (!i_pins.cmd_latch && i_pins.write_protect_n) begin
        pgbuf[col] = i_host_io;
        col = col + 4'h1;
      end
    end
  end
  always @(negedge i_pins.output_strobe_n) begin
    if (!i_pins.chip_sel_n && !i_pins.cmd_latch && !i_pins.addr_latch) begin
      dout = cache[col];
      drv = 1'b1;
      col = col + 4'h1;
    end
  end
  // short strobe-high mode: drivers stay on until these edges
  always @(posedge i_pins.cmd_latch or posedge i_pins.addr_latch
           or posedge i_pins.chip_sel_n or negedge i_pins.write_strobe_n) drv = 1'b0;
  // undriven bus shows the inverse of the last byte, never a stale copy
  assign o_io = i_host_oe ? i_host_io : (drv ? dout : ~dout);
endmodule

// file: tb/nfc_host_bench.sv
`timescale 1ns/1ps
module nfc_host_bench;
  import nfc_pkg::*;
  logic       i_core_clk;
  logic       i_srst;
  nfc_req_s   i_req;
  logic       i_req_valid;
  logic       i_wp_release;
  logic       i_rd_ready;
  logic       o_req_ready;
  logic       o_busy;
  logic       o_illegal;
  logic       o_rd_valid;
  logic       o_io_oe;
  logic       rb_n;
  logic [7:0] o_rd_data;
  logic [7:0] o_io_out;
  logic [7:0] io_wire;
  nfc_pins_s  o_pins;
  int         num_errors = 0;
  int         check_count = 0;
  int         busy_cnt = 0;
  int         ill_cnt = 0;
  int         b;

  nfc_host nfc_host_inst (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_req(i_req),
    .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_wp_release(i_wp_release),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .i_rd_ready(i_rd_ready),
    .o_busy(o_busy), .o_illegal(o_illegal), .o_pins(o_pins), .o_io_out(o_io_out),
    .o_io_oe(o_io_oe), .i_io_in(io_wire), .i_ready_busy_n(rb_n));
  nfc_dev_model u_dev (.i_pins(o_pins), .i_host_io(o_io_out), .i_host_oe(o_io_oe),
    .o_io(io_wire), .o_ready_busy_n(rb_n));

  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    if (rb_n === 1'b0) busy_cnt++;
    if (o_illegal === 1'b1) ill_cnt++;
  end
  // =====================================================================
  // shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] pat(input int r, input int c);
    return 8'(r * 16 + c) ^ 8'h5A;
  endfunction
  task automatic req(input nfc_op_e op, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge i_core_clk);
    i_req.op = op;
    i_req.data = d;
    i_req_valid = 1'b1;
    #1;
    while (o_req_ready !== 1'b1 && n < 3000) begin @(negedge i_core_clk); #1; n++; end
    @(negedge i_core_clk);
    i_req_valid = 1'b0;
    while (o_busy !== 1'b0 && n < 6000) begin @(negedge i_core_clk); n++; end
  endtask
  task automatic adr(input logic [3:0] c, input logic [1:0] r, input int n);
    req(NFC_OP_ADDR, {4'h0, c});
    req(NFC_OP_ADDR, 8'h00);
    if (n > 2) begin
      req(NFC_OP_ADDR, {6'h00, r});
      req(NFC_OP_ADDR, 8'h00);
      req(NFC_OP_ADDR, 8'h00);
    end
  endtask
  task automatic rd(input logic [7:0] exp);
    int n;
    n = 0;
    req(NFC_OP_RD, 8'h00);
    while (o_rd_valid !== 1'b1 && n < 100) begin @(negedge i_core_clk); n++; end
    chk(o_rd_data, exp);
    i_rd_ready = 1'b1;
    @(negedge i_core_clk);
    i_rd_ready = 1'b0;
  endtask
  task automatic busy_seen;
    chk({7'h00, busy_cnt > b}, 8'h01);
  endtask
  // =====================================================================
  // scenarios
  task automatic t_reset;
    chk({2'b00, o_pins}, 8'h0E);
    chk({7'h00, o_io_oe}, 8'h00);
    // ready is still unsynchronised here, so a read setup must be refused
    b = ill_cnt;
    req(NFC_OP_CMD, CMD_READ_SETUP);
    repeat (2) @(negedge i_core_clk);
    chk(8'(ill_cnt - b), 8'h01);
    $display("reset test done");
  endtask
  task automatic t_poweron;
    b = busy_cnt;
    adr(4'h2, 2'h1, 5);
    req(NFC_OP_CMD, CMD_READ_START);
    busy_seen();
    rd(pat(1, 2));
    rd(pat(1, 3));
    req(NFC_OP_CMD, CMD_COL_OUT);
    adr(4'h9, 2'h0, 2);
    req(NFC_OP_CMD, CMD_COL_OUT_GO);
    rd(pat(1, 9));
    $display("power-on read test done");
  endtask
  task automatic t_cache;
    req(NFC_OP_CMD, CMD_READ_SETUP);
    adr(4'h0, 2'h0, 5);
    req(NFC_OP_CMD, CMD_READ_START);
    rd(pat(0, 0));
    b = busy_cnt;
    req(NFC_OP_CMD, CMD_CACHE_NEXT);
    busy_seen();
    rd(pat(1, 0));
    req(NFC_OP_CMD, CMD_CACHE_LAST);
    rd(pat(2, 0));
    $display("cache read test done");
  endtask
  task automatic t_wp;
    i_wp_release = 1'b0;
    b = ill_cnt;
    req(NFC_OP_CMD, CMD_PROG_SETUP);
    repeat (3) @(negedge i_core_clk);
    chk(8'(ill_cnt - b), 8'h01);
    chk({7'h00, o_pins.write_protect_n}, 8'h00);
    $display("write protect test done");
  endtask
  task automatic t_prog;
    i_wp_release = 1'b1;
    repeat (4) @(negedge i_core_clk);
    req(NFC_OP_CMD, CMD_PROG_SETUP);
    adr(4'h0, 2'h3, 5);
    req(NFC_OP_WR, 8'h11);
    req(NFC_OP_WR, 8'h22);
    req(NFC_OP_CMD, CMD_COL_IN);
    adr(4'h8, 2'h0, 2);
    req(NFC_OP_WR, 8'h44);
    b = busy_cnt;
    req(NFC_OP_CMD, CMD_PROG_START);
    busy_seen();
    req(NFC_OP_CMD, CMD_READ_SETUP);
    adr(4'h0, 2'h3, 5);
    req(NFC_OP_CMD, CMD_READ_START);
    rd(8'h11);
    rd(8'h22);
    rd(8'hFF);
    req(NFC_OP_CMD, CMD_COL_OUT);
    adr(4'h8, 2'h0, 2);
    req(NFC_OP_CMD, CMD_COL_OUT_GO);
    rd(8'h44);
    $display("program test done");
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // tests take well under 10000 cycles; this limit means a hang
  initial begin
    #(40 * 40000);
    num_errors++;
    close_out();
  end
  initial begin
    i_srst = 1'b1;
    i_req = '0;
    i_req_valid = 1'b0;
    i_wp_release = 1'b0;
    i_rd_ready = 1'b0;
    repeat (8) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_srst = 1'b0;
    t_reset();
    t_poweron();
    t_cache();
    t_wp();
    t_prog();
    close_out();
  end
endmodule
